//--- rtl/lcag_addr_gen.sv
// Address generator of one data unit: load/store addresses and scaled add/sub.
// Assumes requests from the decoder on clk_sys; results one cycle later.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Modes are linear, circular on the first block size, circular on the second.
// - Only registers 4-7 of either side may wrap; all others are linear.
// - Loads, stores and scaled add/subtract consult the mode register for those eight.
// - Load/store offsets are shifted by 2, 1 or 0 for word, half, byte and added or subtracted.
// - Pre-modify and plain offset forms access memory at the computed address.
// - Post-modify forms access memory at the old base; only the new base changes.
// - Scaled add/subtract shift the first source by the size and write the destination.
// - In circular mode only bits N..0 change and bits 31..N+1 keep the base.
// - Block size is in bytes, never scaled by the access size.
// - Block field N gives a buffer of 2^(N+1) bytes, so 4 gives 32 bytes.
// - A long form uses base 14 or 15 of side B plus a 15-bit unsigned constant, added.
// - The long form never modifies the base register.
// - Offsets come from an offset register or a 5-bit unsigned constant.
// - Mode field bits: modify, register offset, post, add.
module lcag_addr_gen
	import lcag_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_valid,
	input wire lcag_op_t req_op,
	input wire logic req_side_b,
	input wire logic [LCAG_REG_IDX_W-1:0] req_base_index,
	input wire logic [31:0] req_base_value,
	input wire logic [31:0] req_offset_value,
	input wire logic [LCAG_SHORT_CST_W-1:0] req_short_const,
	input wire logic [LCAG_LONG_CST_W-1:0] req_long_const,
	input wire logic req_long_form,
	input wire logic [3:0] req_mode_field,
	input wire logic [1:0] req_size,
	input wire logic [31:0] addressing_mode_register,
	output logic out_valid,
	output logic out_is_mem,
	output logic [31:0] out_mem_address,
	output logic out_writeback,
	output logic [31:0] out_writeback_value,
	output logic out_fault
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	lcag_calc_if calc ();

	logic [31:0] offset_sel;
	logic eligible;
	logic [2:0] mode_slot;
	logic [1:0] amode;
	logic is_mem;
	logic long_ok;
	logic legal;
	logic modify;
	logic post;

	always_comb begin
		is_mem = (req_op == LCAG_OP_MEM);
		long_ok = req_side_b &&
			(req_base_index == LCAG_LONG_BASE_LO || req_base_index == LCAG_LONG_BASE_HI);
		legal = (req_op == LCAG_OP_MEM || req_op == LCAG_OP_SCALED_ADD ||
			req_op == LCAG_OP_SCALED_SUB) && (!req_long_form || (is_mem && long_ok));
		if (req_long_form) begin
			offset_sel = {17'h0_0000, req_long_const};
		end else if (req_mode_field[LCAG_MODE_REG_BIT]) begin
			offset_sel = req_offset_value;
		end else begin
			offset_sel = {27'h000_0000, req_short_const};
		end
		eligible = !req_long_form && req_base_index >= LCAG_CIRC_FIRST_REG &&
			req_base_index <= LCAG_CIRC_LAST_REG;
		mode_slot = {req_side_b, req_base_index[1:0]};
		amode = addressing_mode_register[mode_slot*LCAG_MODE_SLOT_W +: LCAG_MODE_SLOT_W];
		modify = is_mem && !req_long_form && req_mode_field[LCAG_MODE_MODIFY_BIT];
		post = modify && req_mode_field[LCAG_MODE_POST_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Arithmetic

	always_comb begin
		// scale first source by data size
		calc.base = req_base_value;
		calc.scaled = offset_sel << req_size;
		if (req_op == LCAG_OP_SCALED_SUB) begin
			calc.subtract = 1'b1;
		end else if (req_op == LCAG_OP_SCALED_ADD || req_long_form) begin
			calc.subtract = 1'b0;
		end else begin
			calc.subtract = !req_mode_field[LCAG_MODE_ADD_BIT];
		end
		// linear or one of two circular modes
		calc.circular = eligible &&
			(amode == LCAG_AMODE_CIRC_FIRST || amode == LCAG_AMODE_CIRC_SECOND);
		calc.block_n = (amode == LCAG_AMODE_CIRC_SECOND) ?
			addressing_mode_register[LCAG_SECOND_BLOCK_LSB +: LCAG_BK_W] :
			addressing_mode_register[LCAG_FIRST_BLOCK_LSB +: LCAG_BK_W];
	end

	lcag_wrap_unit u_wrap (
		.c(calc.calc)
	);

	////////////////////////////////////////////////////////////////////////
	// Result registers

	logic valid_ff, nxt_valid;
	logic is_mem_ff, nxt_is_mem;
	logic [31:0] addr_ff, nxt_addr;
	logic wb_ff, nxt_wb;
	logic [31:0] wb_value_ff, nxt_wb_value;
	logic fault_ff, nxt_fault;

	always_comb begin
		nxt_valid = req_valid && legal;
		nxt_is_mem = req_valid && legal && is_mem;
		nxt_fault = req_valid && !legal;
		nxt_addr = addr_ff;
		nxt_wb_value = wb_value_ff;
		nxt_wb = 1'b0;
		if (req_valid && legal) begin
			// computed address for pre and plain forms
			nxt_addr = (is_mem && !post) ? calc.result : req_base_value;
			nxt_wb = modify || !is_mem;
			nxt_wb_value = calc.result;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			valid_ff <= 1'b0;
			is_mem_ff <= 1'b0;
			addr_ff <= LCAG_WORD_RST;
			wb_ff <= 1'b0;
			wb_value_ff <= LCAG_WORD_RST;
			fault_ff <= 1'b0;
		end else begin
			valid_ff <= nxt_valid;
			is_mem_ff <= nxt_is_mem;
			addr_ff <= nxt_addr;
			wb_ff <= nxt_wb;
			wb_value_ff <= nxt_wb_value;
			fault_ff <= nxt_fault;
		end
	end

	assign out_valid = valid_ff;
	assign out_is_mem = is_mem_ff;
	assign out_mem_address = addr_ff;
	assign out_writeback = wb_ff;
	assign out_writeback_value = wb_value_ff;
	assign out_fault = fault_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	logic [31:0] chk_scaled;
	logic chk_plain;
	assign chk_scaled = offset_sel << req_size;
	assign chk_plain = req_valid && is_mem && !req_long_form && legal && !calc.circular;

	a_lin_offset_addr: assert property (
		chk_plain && !req_mode_field[LCAG_MODE_MODIFY_BIT] && req_mode_field[LCAG_MODE_ADD_BIT]
		|=> out_mem_address == $past(req_base_value) + $past(chk_scaled) && !out_writeback)
		else $error("linear offset address wrong");

	a_pre_uses_sum: assert property (
		chk_plain && req_mode_field == 4'h8
		|=> out_mem_address == $past(req_base_value) - $past(chk_scaled)
			&& out_writeback_value == out_mem_address)
		else $error("pre-decrement address wrong");

	a_post_uses_base: assert property (
		req_valid && legal && post
		|=> out_mem_address == $past(req_base_value) && out_writeback)
		else $error("post form did not use old base");

	a_scaled_sub_lin: assert property (
		req_valid && req_op == LCAG_OP_SCALED_SUB && !calc.circular && !req_long_form
		|=> out_valid && !out_is_mem
			&& out_writeback_value == $past(req_base_value) - $past(chk_scaled))
		else $error("scaled subtract wrong");

	a_circ_high_kept: assert property (
		req_valid && legal && calc.circular && !is_mem
		|=> ((out_writeback_value ^ $past(req_base_value)) & $past(calc.keep_mask)) == 32'h0000_0000)
		else $error("circular result changed upper bits");

	a_block_32_bytes: assert property (
		req_valid && legal && calc.circular && calc.block_n == 5'h04 && !post
		|=> out_mem_address[31:5] == $past(req_base_value[31:5]))
		else $error("block field 4 not bounded to 32 bytes");

	a_other_regs_lin: assert property (
		req_valid && req_op == LCAG_OP_SCALED_ADD && req_base_index > LCAG_CIRC_LAST_REG
			&& !req_long_form
		|=> out_writeback_value == $past(req_base_value) + $past(chk_scaled))
		else $error("ineligible register wrapped");

	a_long_no_modify: assert property (
		req_valid && req_long_form && is_mem && long_ok
		|=> !out_writeback && out_mem_address ==
			$past(req_base_value) + ($past({17'h0_0000, req_long_const}) << $past(req_size)))
		else $error("long form address or write-back wrong");

	a_second_block_sel: assert property (
		req_valid && eligible && amode == LCAG_AMODE_CIRC_SECOND
		|-> calc.circular && calc.block_n == addressing_mode_register[25:21])
		else $error("second block size not selected");

	a_bad_long_fault: assert property (
		req_valid && req_long_form && !long_ok |=> out_fault && !out_valid)
		else $error("illegal long base accepted");

	c_post_circ: cover property (req_valid && post && calc.circular ##1 out_writeback);
	c_long_form: cover property (req_valid && req_long_form && long_ok ##1 out_valid);
	c_sub_circ: cover property (req_valid && req_op == LCAG_OP_SCALED_SUB && calc.circular);
	c_fault: cover property (out_fault);

endmodule
`default_nettype wire

//--- rtl/lcag_pkg.sv
// Constants and types of the linear/circular address generator.
// Assumes one CPU clock; the decoder presents one request per cycle.
package lcag_pkg;

	localparam int LCAG_DATA_W = 32;
	localparam int LCAG_REG_IDX_W = 4;
	localparam int LCAG_BK_W = 5;
	localparam int LCAG_SHORT_CST_W = 5;
	localparam int LCAG_LONG_CST_W = 15;

	// Instruction mode field bit positions
	localparam int LCAG_MODE_MODIFY_BIT = 3;
	localparam int LCAG_MODE_REG_BIT = 2;
	localparam int LCAG_MODE_POST_BIT = 1;
	localparam int LCAG_MODE_ADD_BIT = 0;

	// Circular-eligible and long-offset base register numbers
	localparam logic [LCAG_REG_IDX_W-1:0] LCAG_CIRC_FIRST_REG = 4'h4;
	localparam logic [LCAG_REG_IDX_W-1:0] LCAG_CIRC_LAST_REG = 4'h7;
	localparam logic [LCAG_REG_IDX_W-1:0] LCAG_LONG_BASE_LO = 4'hE;
	localparam logic [LCAG_REG_IDX_W-1:0] LCAG_LONG_BASE_HI = 4'hF;

	// Addressing mode register layout: 2 bits per eligible register
	localparam int LCAG_MODE_SLOT_W = 2;
	localparam int LCAG_FIRST_BLOCK_LSB = 16;
	localparam int LCAG_SECOND_BLOCK_LSB = 21;
	localparam logic [1:0] LCAG_AMODE_LINEAR = 2'h0;
	localparam logic [1:0] LCAG_AMODE_CIRC_FIRST = 2'h1;
	localparam logic [1:0] LCAG_AMODE_CIRC_SECOND = 2'h2;

	// Access size code is also the offset shift
	localparam logic [1:0] LCAG_SIZE_BYTE = 2'h0;
	localparam logic [1:0] LCAG_SIZE_HALF = 2'h1;
	localparam logic [1:0] LCAG_SIZE_WORD = 2'h2;

	localparam logic [LCAG_DATA_W-1:0] LCAG_WORD_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		LCAG_OP_MEM,
		LCAG_OP_SCALED_ADD,
		LCAG_OP_SCALED_SUB
	} lcag_op_t;

endpackage

//--- rtl/lcag_calc_if.sv
// Carrier between the address generator and its wrap arithmetic.
// Purely combinational signals, no clock.
`timescale 1ns/100ps
`default_nettype none
interface lcag_calc_if;
	logic [31:0] base;
	logic [31:0] scaled;
	logic subtract;
	logic circular;
	logic [4:0] block_n;
	logic [31:0] result;
	logic [31:0] keep_mask;

	modport calc (input base, scaled, subtract, circular, block_n, output result, keep_mask);
	modport user (output base, scaled, subtract, circular, block_n, input result, keep_mask);
endinterface
`default_nettype wire

//--- rtl/lcag_wrap_unit.sv
// Add/subtract with optional circular wrap of the low N+1 bits.
// Combinational; driven by the address generator through lcag_calc_if.
`timescale 1ns/100ps
`default_nettype none
module lcag_wrap_unit (
	lcag_calc_if.calc c
);
	logic [31:0] raw;

	always_comb begin
		raw = c.subtract ? (c.base - c.scaled) : (c.base + c.scaled);
		// Bits above N stay those of the base; shift by 32 clears the mask
		c.keep_mask = 32'hFFFF_FFFF << ({1'b0, c.block_n} + 6'h01);
		if (c.circular) begin
			c.result = (c.base & c.keep_mask) | (raw & ~c.keep_mask);
		end else begin
			c.result = raw;
		end
	end
endmodule
`default_nettype wire

//--- testbench/lcag_dec_model.sv
// Decoder-side model: presents one request per call to the address generator.
// Assumes a free-running clk_sys; callers enter just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module lcag_dec_model
	import lcag_pkg::*;
(
	input wire logic clk_sys,
	output logic req_valid,
	output lcag_op_t req_op,
	output logic req_side_b,
	output logic [3:0] req_base_index,
	output logic [31:0] req_base_value,
	output logic [31:0] req_offset_value,
	output logic [4:0] req_short_const,
	output logic [14:0] req_long_const,
	output logic req_long_form,
	output logic [3:0] req_mode_field,
	output logic [1:0] req_size,
	output logic [31:0] addressing_mode_register
);
	initial begin
		req_valid = 1'b0;
		req_op = LCAG_OP_MEM;
		{req_side_b, req_base_index, req_base_value, req_offset_value} = '0;
		{req_short_const, req_long_const, req_long_form, req_mode_field} = '0;
		{req_size, addressing_mode_register} = '0;
	end

	// Valid stays high so calls run back to back
	task automatic send(input logic [1:0] op, input logic sb, input logic [3:0] idx,
		input logic [31:0] b, o, input logic [4:0] sc, input logic [14:0] lc, input logic lf,
		input logic [3:0] m, input logic [1:0] sz, input logic [31:0] mreg);
		req_op = lcag_op_t'(op);
		{req_side_b, req_base_index, req_base_value, req_offset_value} = {sb, idx, b, o};
		{req_short_const, req_long_const, req_long_form, req_mode_field} = {sc, lc, lf, m};
		{req_size, addressing_mode_register} = {sz, mreg};
		req_valid = 1'b1;
		@(posedge clk_sys);
		#1;
	endtask

	// Released operands no longer show the last value
	task automatic idle();
		req_valid = 1'b0;
		req_base_value = ~req_base_value;
		req_offset_value = ~req_offset_value;
	endtask
endmodule
`default_nettype wire

//--- testbench/test_linear_circular_address_generator.sv
// Self-checking bench of the address generator against an integer model.
// Assumes the decoder model drives requests; results one cycle later.
`timescale 1ns/100ps
`default_nettype none
module test_linear_circular_address_generator
	import lcag_pkg::*;
;
	logic clk_sys = 1'b0, rst = 1'b1;
	logic req_valid, req_side_b, req_long_form;
	lcag_op_t req_op;
	logic [3:0] req_base_index, req_mode_field;
	logic [31:0] req_base_value, req_offset_value, addressing_mode_register;
	logic [4:0] req_short_const;
	logic [14:0] req_long_const;
	logic [1:0] req_size;
	logic out_valid, out_is_mem, out_writeback, out_fault;
	logic [31:0] out_mem_address, out_writeback_value;
	int n_mismatch = 0, n_tests = 0, cycles = 0, i;
	integer seed = 32'h19dc;
	logic [31:0] r, q;

	always #10 clk_sys = ~clk_sys;

	lcag_dec_model u_dec (.clk_sys, .req_valid, .req_op, .req_side_b, .req_base_index,
		.req_base_value, .req_offset_value, .req_short_const, .req_long_const, .req_long_form,
		.req_mode_field, .req_size, .addressing_mode_register);
	lcag_addr_gen uut (.clk_sys, .rst, .req_valid, .req_op, .req_side_b, .req_base_index,
		.req_base_value, .req_offset_value, .req_short_const, .req_long_const, .req_long_form,
		.req_mode_field, .req_size, .addressing_mode_register, .out_valid, .out_is_mem,
		.out_mem_address, .out_writeback, .out_writeback_value, .out_fault);

	////////////////////////////////////////////////////////////////////////////////
	// Result {fault, mem, writeback, address, writeback value}
	function automatic logic [66:0] model(input logic [1:0] op, input logic sb,
		input logic [3:0] idx, input logic [31:0] b, o, input logic [4:0] sc,
		input logic [14:0] lc, input logic lf, input logic [3:0] m, input logic [1:0] sz,
		input logic [31:0] mreg);
		logic [31:0] off, res, mask;
		logic [1:0] am;
		off = (lf ? {17'h0_0000, lc} : m[2] ? o : {27'h000_0000, sc}) << sz;
		res = (lf || op == 2'h1 || (op == 2'h0 && m[0])) ? b + off : b - off;
		am = mreg[{sb, idx[1:0], 1'b0} +: 2];
		mask = (32'h0000_0002 << (am[1] ? mreg[25:21] : mreg[20:16])) - 32'h0000_0001;
		if (!lf && idx[3:2] == 2'h1 && (am == 2'h1 || am == 2'h2))
			res = (b & ~mask) | (res & mask);
		if (op == 2'h3 || (lf && (op != 2'h0 || !sb || idx < 4'hE)))
			return {3'b100, 64'h0};
		if (op != 2'h0)
			return {3'b001, 32'h0, res};
		return {2'b01, m[3] && !lf, (m[3] && m[1] && !lf) ? b : res, res};
	endfunction

	task automatic check(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic run(input logic [1:0] op, input logic sb, input logic [3:0] idx,
		input logic [31:0] b, o, input logic [4:0] sc, input logic [14:0] lc, input logic lf,
		input logic [3:0] m, input logic [1:0] sz, input logic [31:0] mreg);
		logic [66:0] e;
		e = model(op, sb, idx, b, o, sc, lc, lf, m, sz, mreg);
		u_dec.send(op, sb, idx, b, o, sc, lc, lf, m, sz, mreg);
		check({28'h000_0000, out_fault, out_valid, out_is_mem, out_writeback},
			{28'h000_0000, e[66], !e[66], e[65:64]});
		if (!e[66] && e[65])
			check(out_mem_address, e[63:32]);
		if (e[64])
			check(out_writeback_value, e[31:0]);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		run(2'h0, 1'b0, 4'h1, 32'h0000_0100, 32'h0, 5'h01, 15'h0, 1'b0, 4'hB, 2'h2, 32'h0);
		run(2'h1, 1'b0, 4'h1, 32'h0000_0100, 32'h0, 5'h0B, 15'h0, 1'b0, 4'h0, 2'h1, 32'h0);
		run(2'h0, 1'b0, 4'h4, 32'h0000_0100, 32'h0, 5'h09, 15'h0, 1'b0, 4'h9, 2'h2,
			32'h0004_0001);
		run(2'h1, 1'b0, 4'h4, 32'h0000_0100, 32'h0, 5'h13, 15'h0, 1'b0, 4'h0, 2'h1,
			32'h0004_0001);
		run(2'h1, 1'b0, 4'h4, 32'h0000_0100, 32'h0, 5'h0B, 15'h0, 1'b0, 4'h0, 2'h0,
			32'h0002_0001);
		run(2'h2, 1'b1, 4'h5, 32'h0000_1234, 32'h0, 5'h1F, 15'h0, 1'b0, 4'h0, 2'h2,
			32'h0060_0800);
		run(2'h2, 1'b0, 4'h5, 32'h0000_1234, 32'h0, 5'h1F, 15'h0, 1'b0, 4'h0, 2'h2,
			32'h0060_0800);
		run(2'h0, 1'b0, 4'hC, 32'h0000_1234, 32'h0, 5'h1F, 15'h0, 1'b0, 4'h8, 2'h2,
			32'hFFFF_FFFF);
		run(2'h0, 1'b1, 4'hE, 32'h8000_0000, 32'h0, 5'h0, 15'h7FFF, 1'b1, 4'hA, 2'h2,
			32'h0004_5555);
		run(2'h0, 1'b0, 4'hF, 32'h8000_0000, 32'h0, 5'h0, 15'h0001, 1'b1, 4'h1, 2'h0, 32'h0);
		run(2'h3, 1'b0, 4'h0, 32'h0, 32'h0, 5'h0, 15'h0, 1'b0, 4'h1, 2'h0, 32'h0);
		for (i = 0; i < 16; i++)
			run(2'h0, 1'b0, 4'h6, 32'h0000_1F00, 32'h0000_0007, 5'h1D, 15'h0, 1'b0, i[3:0],
				2'h2, 32'h0004_0010);
		for (i = 0; i < 300; i++) begin
			r = $random(seed);
			q = $random(seed);
			run(r[1:0], q[23:21] == 3'h0 || r[2], q[23:21] == 3'h0 ? {3'h7, r[3]} : r[6:3],
				$random(seed), $random(seed), r[11:7], q[20:6], q[23:21] == 3'h0, q[3:0],
				q[5:4] == 2'h3 ? 2'h2 : q[5:4], $random(seed));
		end
		u_dec.idle();
		@(posedge clk_sys);
		#1;
		check({31'h0, out_valid}, 32'h0);
		// Mid-run reset clears results; first request right after release
		rst = 1'b1;
		#1;
		check(out_mem_address, LCAG_WORD_RST);
		check(out_writeback_value, LCAG_WORD_RST);
		@(posedge clk_sys);
		#1;
		rst = 1'b0;
		run(2'h1, 1'b0, 4'h4, 32'h0000_0100, 32'h0, 5'h13, 15'h0, 1'b0, 4'h0, 2'h1,
			32'h0004_0001);
		stop_test();
	end
endmodule
`default_nettype wire
